// file: src/energy_bank_pkg.sv
package energy_bank_pkg;
  localparam int ADDR_W   = 12;
  localparam int IDX_W    = ADDR_W - 2;
  localparam int SAMPLE_W = 32;
  localparam int RAW_W    = 48;
  localparam int SQ_W     = 64;
  localparam int N_PULSE  = 4;
  localparam int N_CH     = 4;
  localparam int GAIN_FRAC = 14;

  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_GAIN        = 10'h040;
  localparam logic [IDX_W-1:0] IDX_CONFIG      = 10'h042;
  localparam logic [IDX_W-1:0] IDX_PULSE0      = 10'h045;
  localparam logic [IDX_W-1:0] IDX_PULSE1      = 10'h046;
  localparam logic [IDX_W-1:0] IDX_PULSE2      = 10'h047;
  localparam logic [IDX_W-1:0] IDX_PULSE3      = 10'h048;
  localparam logic [IDX_W-1:0] IDX_TOTAL_REAL  = 10'h085;
  localparam logic [IDX_W-1:0] IDX_E0_REAL     = 10'h086;
  localparam logic [IDX_W-1:0] IDX_E1_REAL     = 10'h087;
  localparam logic [IDX_W-1:0] IDX_TOTAL_REACT = 10'h08a;
  localparam logic [IDX_W-1:0] IDX_E0_REACT    = 10'h08b;
  localparam logic [IDX_W-1:0] IDX_E1_REACT    = 10'h08c;
  localparam logic [IDX_W-1:0] IDX_E0_ISQ      = 10'h08f;
  localparam logic [IDX_W-1:0] IDX_E1_ISQ      = 10'h090;
  localparam logic [IDX_W-1:0] IDX_E0_VSQ      = 10'h093;
  localparam logic [IDX_W-1:0] IDX_E1_VSQ      = 10'h094;
  localparam logic [IDX_W-1:0] IDX_E0_IRES     = 10'h099;
  localparam logic [IDX_W-1:0] IDX_E1_IRES     = 10'h09a;
  localparam logic [IDX_W-1:0] IDX_FREQ        = 10'h0a0;

  localparam logic [31:0] GAIN_RESET   = 32'h00004000;
  localparam logic [31:0] ACCUM_RESET  = 32'h00000000;
  localparam logic [2:0]  EQU_TOTAL    = 3'h2;
  localparam logic [1:0]  PHASE_A      = 2'h0;
  localparam logic [1:0]  PHASE_B      = 2'h1;
  localparam logic [1:0]  HG_SHIFT     = 2'h3;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  typedef struct packed {
    logic [1:0] phase_select;
    logic       channel_b_high_gain;
    logic       channel_a_high_gain;
    logic [2:0] equation_select;
  } engine_configuration_s;
  localparam int CFG_W = $bits(engine_configuration_s);
  localparam engine_configuration_s CONFIG_RESET = '0;

  typedef struct packed {
    logic signed [RAW_W-1:0]       real0;
    logic signed [RAW_W-1:0]       real1;
    logic signed [RAW_W-1:0]       react0;
    logic signed [RAW_W-1:0]       react1;
    logic signed [RAW_W-1:0]       vsq0;
    logic signed [RAW_W-1:0]       vsq1;
    logic [SQ_W-1:0]               isq0;
    logic [SQ_W-1:0]               isq1;
    logic [31:0]                   freq_a;
    logic [31:0]                   freq_b;
    logic [N_PULSE-1:0][31:0]      pulse_inc;
  } engine_pass_s;

  // channels 0,1 are voltages, 2,3 are currents a,b
  typedef struct packed {
    logic signed [SAMPLE_W-1:0] curr_b;
    logic signed [SAMPLE_W-1:0] curr_a;
    logic signed [SAMPLE_W-1:0] volt_b;
    logic signed [SAMPLE_W-1:0] volt_a;
  } sample_set_s;

  localparam logic signed [71:0] SAT_MAX = 72'sh7fffffff;
  localparam logic signed [71:0] SAT_MIN = -72'sh80000000;

  function automatic logic [31:0] sat32(input logic signed [71:0] v);
    if (v > SAT_MAX) return 32'h7fffffff;
    if (v < SAT_MIN) return 32'h80000000;
    return v[31:0];
  endfunction

  function automatic logic [31:0] merge_strb(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) r[b*8 +: 8] = nw[b*8 +: 8];
    end
    return r;
  endfunction
endpackage

// file: src/energy_result_transfer_bank.sv
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ps
// Summary of operation
// - gain word scales every voltage, current channel
// - gain word resets to 16384, unity
// - interrupt only after new results are stored
// - results change only in the ending pass
// - results hold steady between passes
// - energy results are signed 32-bit
// - sums scaled down for overflow headroom
// - overflowing energy, sample outputs never wrap sign; pulse accumulators wrap
// - total real energy when equation is 2
// - element 0, 1 real energy stored
// - reactive total and element sums stored
// - high-gain current channel multiplied by eight
// - frequency taken from selected phase
// - element 0, 1 squared current sums
// - element 0, 1 squared voltage sums
// - real and reactive pulse roll-over accumulators
// - third and fourth pulse roll-over accumulators
// - squared current high residual words stored
// - phase select zero picks phase A
module energy_result_transfer_bank
  import energy_bank_pkg::*;
#(
  parameter int HEADROOM_SHIFT = 0
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [ADDR_W-1:0]     awaddr,
  input  wire logic [2:0]            awprot,
  input  wire logic                  awvalid,
  output logic                       awready,
  input  wire logic [31:0]           wdata,
  input  wire logic [3:0]            wstrb,
  input  wire logic                  wvalid,
  output logic                       wready,
  output logic [1:0]                 bresp,
  output logic                       bvalid,
  input  wire logic                  bready,
  input  wire logic [ADDR_W-1:0]     araddr,
  input  wire logic [2:0]            arprot,
  input  wire logic                  arvalid,
  output logic                       arready,
  output logic [31:0]                rdata,
  output logic [1:0]                 rresp,
  output logic                       rvalid,
  input  wire logic                  rready,
  input  wire logic                  pass_done,
  input  wire engine_pass_s          pass_results,
  input  wire logic                  sample_valid,
  input  wire sample_set_s           samples,
  output logic                       scaled_valid,
  output sample_set_s                scaled,
  output engine_configuration_s      engine_config,
  output logic                       transfer_ready_interrupt
);

  logic [31:0]              gain;
  logic [31:0]              total_real;
  logic [31:0]              e0_real;
  logic [31:0]              e1_real;
  logic [31:0]              total_react;
  logic [31:0]              e0_react;
  logic [31:0]              e1_react;
  logic [31:0]              e0_isq;
  logic [31:0]              e1_isq;
  logic [31:0]              e0_vsq;
  logic [31:0]              e1_vsq;
  logic [31:0]              e0_ires;
  logic [31:0]              e1_ires;
  logic [31:0]              freq;
  logic [N_PULSE-1:0][31:0] pulse_accum;
  logic                     published;

  function automatic logic [31:0] scale_sat(
      input logic signed [RAW_W-1:0] v);
    logic signed [71:0] w;
    w = 72'(v);
    return sat32(w >>> HEADROOM_SHIFT);
  endfunction

  // sample gain path
  logic [N_CH*SAMPLE_W-1:0] samp_flat;
  logic [N_CH*SAMPLE_W-1:0] scal_flat;
  logic [N_CH-1:0]          hg_vec;
  assign samp_flat = samples;
  assign hg_vec = {engine_config.channel_b_high_gain,
                   engine_config.channel_a_high_gain, 2'h0};

  for (genvar g = 0; g < N_CH; g++) begin : g_ch
    logic signed [SAMPLE_W-1:0] s;
    logic signed [71:0]         prod;
    logic signed [71:0]         shifted;
    logic [1:0]                 sh;
    assign s = samp_flat[g*SAMPLE_W +: SAMPLE_W];
    assign sh = hg_vec[g] ? HG_SHIFT : 2'h0;
    assign prod = 72'(s) * 72'($signed({1'b0, gain}));
    assign shifted = (prod <<< sh) >>> GAIN_FRAC;
    assign scal_flat[g*SAMPLE_W +: SAMPLE_W] = sat32(shifted);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scaled_valid <= 1'b0;
      scaled       <= '0;
    end else begin
      scaled_valid <= sample_valid;
      if (sample_valid) scaled <= sample_set_s'(scal_flat);
    end
  end

  // next transfer values, taken only on the pass strobe
  logic [31:0]        next_e0_real;
  logic [31:0]        next_e1_real;
  logic [31:0]        next_e0_react;
  logic [31:0]        next_e1_react;
  logic [31:0]        next_total_real;
  logic [31:0]        next_total_react;
  logic [31:0]        next_freq;
  logic signed [71:0] real_sum;
  logic signed [71:0] react_sum;
  logic               use_total;

  assign next_e0_real  = scale_sat(pass_results.real0);
  assign next_e1_real  = scale_sat(pass_results.real1);
  assign next_e0_react = scale_sat(pass_results.react0);
  assign next_e1_react = scale_sat(pass_results.react1);
  assign real_sum  = 72'($signed(next_e0_real)) +
                     72'($signed(next_e1_real));
  assign react_sum = 72'($signed(next_e0_react)) +
                     72'($signed(next_e1_react));
  assign use_total = engine_config.equation_select == EQU_TOTAL;
  // single-element equations report element 0 as the total
  assign next_total_real  = use_total ? sat32(real_sum)
                                      : next_e0_real;
  assign next_total_react = use_total ? sat32(react_sum)
                                      : next_e0_react;
  // phase B only on code 1; other codes fall back to phase A
  assign next_freq = (engine_config.phase_select == PHASE_B) ?
                     pass_results.freq_b : pass_results.freq_a;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      total_real  <= '0;
      e0_real     <= '0;
      e1_real     <= '0;
      total_react <= '0;
      e0_react    <= '0;
      e1_react    <= '0;
      e0_isq      <= '0;
      e1_isq      <= '0;
      e0_vsq      <= '0;
      e1_vsq      <= '0;
      e0_ires     <= '0;
      e1_ires     <= '0;
      freq        <= '0;
    end else if (pass_done) begin
      total_real  <= next_total_real;
      e0_real     <= next_e0_real;
      e1_real     <= next_e1_real;
      total_react <= next_total_react;
      e0_react    <= next_e0_react;
      e1_react    <= next_e1_react;
      e0_isq      <= pass_results.isq0[31:0];
      e1_isq      <= pass_results.isq1[31:0];
      e0_ires     <= pass_results.isq0[63:32];
      e1_ires     <= pass_results.isq1[63:32];
      e0_vsq      <= scale_sat(pass_results.vsq0);
      e1_vsq      <= scale_sat(pass_results.vsq1);
      freq        <= next_freq;
    end
  end

  // roll-over accumulators wrap on purpose
  for (genvar k = 0; k < N_PULSE; k++) begin : g_acc
    always_ff @(posedge aclk) begin
      if (!aresetn) pulse_accum[k] <= ACCUM_RESET;
      else if (pass_done)
        pulse_accum[k] <= pulse_accum[k] + pass_results.pulse_inc[k];
    end
  end

  // interrupt trails the update by a cycle so readers see new data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      published                <= 1'b0;
      transfer_ready_interrupt <= 1'b0;
    end else begin
      published                <= pass_done;
      transfer_ready_interrupt <= published;
    end
  end

  // AXI4-Lite write side
  logic [IDX_W-1:0] aw_idx;
  logic             aw_held;
  logic [31:0]      w_data;
  logic [3:0]       w_strb;
  logic             w_held;
  logic             do_write;
  logic             wr_gain;
  logic             wr_cfg;
  logic [31:0]      cfg_word;
  logic [31:0]      merged;

  assign do_write = aw_held && w_held && !bvalid;
  assign wr_gain  = do_write && aw_idx == IDX_GAIN;
  assign wr_cfg   = do_write && aw_idx == IDX_CONFIG;
  assign cfg_word = {{(32-CFG_W){1'b0}}, engine_config};
  assign merged   = merge_strb(wr_gain ? gain : cfg_word, w_data, w_strb);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      aw_held <= 1'b0;
      aw_idx  <= '0;
    end else if (awvalid && awready) begin
      awready <= 1'b0;
      aw_held <= 1'b1;
      aw_idx  <= awaddr[ADDR_W-1:2];
    end else if (do_write) begin
      aw_held <= 1'b0;
    end else if (!aw_held && !bvalid) begin
      awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready <= 1'b0;
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (wvalid && wready) begin
      wready <= 1'b0;
      w_held <= 1'b1;
      w_data <= wdata;
      w_strb <= wstrb;
    end else if (do_write) begin
      w_held <= 1'b0;
    end else if (!w_held && !bvalid) begin
      wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (do_write) begin
      bvalid <= 1'b1;
      bresp  <= (wr_gain || wr_cfg) ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gain          <= GAIN_RESET;
      engine_config <= CONFIG_RESET;
    end else begin
      if (wr_gain) gain <= merged;
      if (wr_cfg) engine_config <= engine_configuration_s'(merged[CFG_W-1:0]);
    end
  end

  // AXI4-Lite read side
  logic [IDX_W-1:0] ar_idx;
  logic [31:0]      rd_word;
  logic             rd_hit;
  assign ar_idx = araddr[ADDR_W-1:2];

  always_comb begin
    rd_hit = 1'b1;
    case (ar_idx)
      IDX_GAIN:        rd_word = gain;
      IDX_CONFIG:      rd_word = cfg_word;
      IDX_PULSE0:      rd_word = pulse_accum[0];
      IDX_PULSE1:      rd_word = pulse_accum[1];
      IDX_PULSE2:      rd_word = pulse_accum[2];
      IDX_PULSE3:      rd_word = pulse_accum[3];
      IDX_TOTAL_REAL:  rd_word = total_real;
      IDX_E0_REAL:     rd_word = e0_real;
      IDX_E1_REAL:     rd_word = e1_real;
      IDX_TOTAL_REACT: rd_word = total_react;
      IDX_E0_REACT:    rd_word = e0_react;
      IDX_E1_REACT:    rd_word = e1_react;
      IDX_E0_ISQ:      rd_word = e0_isq;
      IDX_E1_ISQ:      rd_word = e1_isq;
      IDX_E0_VSQ:      rd_word = e0_vsq;
      IDX_E1_VSQ:      rd_word = e1_vsq;
      IDX_E0_IRES:     rd_word = e0_ires;
      IDX_E1_IRES:     rd_word = e1_ires;
      IDX_FREQ:        rd_word = freq;
      default: begin
        rd_word = '0;
        rd_hit  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= rd_word;
      rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
    end else if (!rvalid) begin
      arready <= 1'b1;
    end
  end

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_pass;
    pass_done ##1 (published && !pass_done);
  endsequence

  sequence s_quiet;
    !pass_done [*2];
  endsequence

  AST_GAIN_RESET: assert property (
    $rose(aresetn) |-> gain == GAIN_RESET)
    else $error("gain word not at unity after reset");

  AST_IRQ_FOLLOWS_PASS: assert property (
    s_pass |=> transfer_ready_interrupt && e0_real == $past(e0_real))
    else $error("interrupt not raised after stored pass");

  AST_IRQ_CAUSE: assert property (
    transfer_ready_interrupt |-> $past(pass_done, 2))
    else $error("interrupt without a pass");

  AST_HOLD: assert property (
    s_quiet |-> $stable(total_real) && $stable(freq) && $stable(e1_vsq))
    else $error("transfer value changed between passes");

  AST_SAT_POS: assert property (
    pass_done && pass_results.real1 > 48'sh00ffffffffff |=>
      e1_real == 32'h7fffffff)
    else $error("positive overflow did not saturate");

  AST_SAT_NEG: assert property (
    pass_done && pass_results.react1 < -48'sh00ffffffffff |=>
      e1_react == 32'h80000000)
    else $error("negative overflow did not saturate");

  AST_TOTAL: assert property (
    pass_done && use_total |=>
      total_real == sat32(72'($signed(e0_real)) +
                          72'($signed(e1_real))))
    else $error("total real energy is not the element sum");

  AST_RESIDUAL: assert property (
    pass_done |=> {e1_ires, e1_isq} == $past(pass_results.isq1))
    else $error("residual and squared sum do not rebuild value");

  AST_FREQ_A: assert property (
    pass_done && engine_config.phase_select == PHASE_A |=>
      freq == $past(pass_results.freq_a))
    else $error("phase A frequency not selected");

  AST_ROLLOVER: assert property (
    pass_done |=> pulse_accum[0] ==
      $past(pulse_accum[0]) + $past(pass_results.pulse_inc[0]))
    else $error("roll-over accumulator did not add increment");

  AST_UNITY: assert property (
    sample_valid && gain == GAIN_RESET && !hg_vec[2] |=>
      scaled.curr_a == $past(samples.curr_a))
    else $error("unity gain altered a sample");

  AST_BHOLD: assert property (
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped before taken");

endmodule

// file: bench/host_processor_model.sv
`timescale 1ns/1ps
module host_processor_model
  import energy_bank_pkg::*;
(
  input  wire logic              aclk,
  output logic [ADDR_W-1:0]      awaddr,
  output logic [2:0]             awprot,
  output logic                   awvalid,
  input  wire logic              awready,
  output logic [31:0]            wdata,
  output logic [3:0]             wstrb,
  output logic                   wvalid,
  input  wire logic              wready,
  input  wire logic [1:0]        bresp,
  input  wire logic              bvalid,
  output logic                   bready,
  output logic [ADDR_W-1:0]      araddr,
  output logic [2:0]             arprot,
  output logic                   arvalid,
  input  wire logic              arready,
  input  wire logic [31:0]       rdata,
  input  wire logic [1:0]        rresp,
  input  wire logic              rvalid,
  output logic                   rready
);
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, awprot, arprot} = '0;
    {wdata, wstrb} = '0;
  end

  task automatic wr(input logic [IDX_W-1:0] idx, input logic [31:0] d,
                    input logic [3:0] s, output logic [1:0] r);
    logic aw_on;
    logic w_on;
    @(posedge aclk);
    awaddr  <= {idx, 2'b00};
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    aw_on = 1'b1;
    w_on = 1'b1;
    // the slave may take address and data at different edges
    while (aw_on || w_on) begin
      @(posedge aclk);
      if (aw_on && awready === 1'b1) begin
        awvalid <= 1'b0;
        aw_on = 1'b0;
      end
      if (w_on && wready === 1'b1) begin
        wvalid <= 1'b0;
        w_on = 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge aclk);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [IDX_W-1:0] idx, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    araddr  <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
endmodule

// file: bench/tb_energy_result_transfer_bank.sv
`timescale 1ns/1ps
module tb_energy_result_transfer_bank
  import energy_bank_pkg::*;
;
  localparam int HS = 1;
  logic                  aclk = 1'b0;
  logic                  aresetn;
  logic [ADDR_W-1:0]     awaddr, araddr;
  logic [2:0]            awprot, arprot;
  logic [31:0]           wdata, rdata;
  logic [3:0]            wstrb;
  logic [1:0]            bresp, rresp;
  logic                  awvalid, awready, wvalid, wready, bvalid, bready;
  logic                  arvalid, arready, rvalid, rready;
  logic                  pass_done, sample_valid, scaled_valid;
  logic                  transfer_ready_interrupt;
  engine_pass_s          pass_results, p;
  sample_set_s           samples, scaled;
  engine_configuration_s engine_config;
  int                    err_total, samples_checked;

  always #4 aclk = ~aclk;

  energy_result_transfer_bank #(.HEADROOM_SHIFT(HS)) DUT (
    .aclk, .aresetn, .awaddr, .awprot, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .pass_done, .pass_results,
    .sample_valid, .samples, .scaled_valid, .scaled, .engine_config,
    .transfer_ready_interrupt);

  host_processor_model host (
    .aclk, .awaddr, .awprot, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arprot, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready);

  function automatic logic [31:0] clip(input logic signed [71:0] v);
    if (v > 72'sh7fffffff) return 32'h7fffffff;
    if (v < -72'sh80000000) return 32'h80000000;
    return v[31:0];
  endfunction

  function automatic logic [31:0] scl(input logic signed [47:0] v);
    logic signed [71:0] t;
    t = 72'(v);
    return clip(t >>> HS);
  endfunction

  function automatic logic [31:0] tot(input logic signed [47:0] a, b);
    logic signed [71:0] t;
    t = 72'($signed(scl(a)));
    return clip(t + 72'($signed(scl(b))));
  endfunction

  function automatic logic [31:0] scale(input logic signed [31:0] s,
                                        input logic [31:0] g, input int sh);
    logic signed [71:0] t;
    t = 72'(s);
    t = t * $signed({40'h0, g});
    return clip((t <<< sh) >>> 14);
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rchk(input logic [IDX_W-1:0] idx, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    host.rd(idx, d, r);
    chk(d, e);
    chk({30'h0, r}, {30'h0, RESP_OKAY});
  endtask

  task automatic samp(input sample_set_s s, input logic [31:0] g,
                      input logic [1:0] hg);
    int sh;
    @(posedge aclk);
    sample_valid <= 1'b1;
    samples <= s;
    @(posedge aclk);
    sample_valid <= 1'b0;
    #1;
    chk({31'h0, scaled_valid}, 32'h1);
    for (int i = 0; i < 4; i++) begin
      sh = ((i == 2 && hg[0]) || (i == 3 && hg[1])) ? 3 : 0;
      chk(scaled[32*i +: 32], scale(s[32*i +: 32], g, sh));
    end
  endtask

  task automatic pass(input engine_pass_s v);
    @(posedge aclk);
    pass_done <= 1'b1;
    pass_results <= v;
    @(posedge aclk);
    pass_done <= 1'b0;
    #1 chk({31'h0, transfer_ready_interrupt}, 32'h0);
    @(posedge aclk);
    #1 chk({31'h0, transfer_ready_interrupt}, 32'h1);
    @(posedge aclk);
    // stale inputs without a pass must leave the results alone
    pass_results <= engine_pass_s'(~v);
    #1 chk({31'h0, transfer_ready_interrupt}, 32'h0);
  endtask

  task automatic t_reset;
    logic [31:0] d;
    logic [1:0]  r;
    rchk(IDX_GAIN, 32'h4000);
    rchk(IDX_E0_REAL, 32'h0);
    rchk(IDX_PULSE0, 32'h0);
    host.rd(10'h3ff, d, r);
    chk(d, 32'h0);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    host.wr(IDX_E0_REAL, 32'h5a5a5a5a, 4'hf, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    rchk(IDX_E0_REAL, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_scale;
    logic [1:0] r;
    samp({32'sh50000000, -32'sd7, 32'sd1234, -32'sd100}, 32'h4000,
         2'b00);
    host.wr(IDX_GAIN, 32'h12348000, 4'h3, r);
    rchk(IDX_GAIN, 32'h8000);
    host.wr(IDX_CONFIG, 32'h18, 4'hf, r);
    chk({25'h0, engine_config}, 32'h18);
    samp({32'sh10000000, -32'sh01000000, 32'sh80000000, 32'sd100},
         32'h8000, 2'b11);
    $display("test scale done");
  endtask

  task automatic t_pass1;
    logic [1:0] r;
    host.wr(IDX_CONFIG, 32'h02, 4'hf, r);
    p = '0;
    p.real0 = 48'sd401;
    p.real1 = 48'sh7fffffff0000;
    p.react0 = -48'sd600;
    p.react1 = -48'sh400000000000;
    p.vsq0 = 48'sd10;
    p.vsq1 = -48'sd7;
    p.isq0 = 64'h0000000380000001;
    p.isq1 = 64'hffffffff00000002;
    p.freq_a = 32'h00011111;
    p.freq_b = 32'h00022222;
    p.pulse_inc = {32'h3, 32'h2, 32'h1, 32'hfffffff0};
    pass(p);
    rchk(IDX_E0_REAL, scl(p.real0));
    rchk(IDX_E1_REAL, scl(p.real1));
    rchk(IDX_TOTAL_REAL, tot(p.real0, p.real1));
    rchk(IDX_E0_REACT, scl(p.react0));
    rchk(IDX_E1_REACT, scl(p.react1));
    rchk(IDX_TOTAL_REACT, tot(p.react0, p.react1));
    rchk(IDX_E0_ISQ, p.isq0[31:0]);
    rchk(IDX_E1_ISQ, p.isq1[31:0]);
    rchk(IDX_E0_IRES, p.isq0[63:32]);
    rchk(IDX_E1_IRES, p.isq1[63:32]);
    rchk(IDX_E0_VSQ, scl(p.vsq0));
    rchk(IDX_E1_VSQ, scl(p.vsq1));
    rchk(IDX_FREQ, p.freq_a);
    for (int k = 0; k < 4; k++) begin
      rchk(IDX_W'(IDX_PULSE0 + k), p.pulse_inc[k]);
    end
    $display("test pass one done");
  endtask

  task automatic t_pass2;
    logic [1:0] r;
    // single-element equation, frequency from phase B
    host.wr(IDX_CONFIG, 32'h21, 4'hf, r);
    p.real0 = -48'sd1000;
    p.react0 = 48'sd77;
    pass(p);
    rchk(IDX_TOTAL_REAL, scl(p.real0));
    rchk(IDX_TOTAL_REACT, scl(p.react0));
    rchk(IDX_FREQ, p.freq_b);
    // accumulators keep counting past the top and wrap
    for (int k = 0; k < 4; k++) begin
      rchk(IDX_W'(IDX_PULSE0 + k), 32'(p.pulse_inc[k] << 1));
    end
    $display("test pass two done");
  endtask

  task automatic end_of_test;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    err_total = 0;
    samples_checked = 0;
    aresetn = 1'b0;
    {pass_done, sample_valid} = '0;
    pass_results = '0;
    samples = '0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_scale;
    t_pass1;
    t_pass2;
    end_of_test;
  end

  // the whole sequence needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    $display("FAIL t=%0t watchdog expired", $time);
    end_of_test;
  end
endmodule
